// ===== common/vcb_pkg.sv
/*
  vcb_pkg: constants and types shared by both ends of the serial bridge link.
  assumes a single 25 MHz core clock on both ends.
*/
package vcb_pkg;
  // clock and line rate
  localparam int VCB_CLK_HZ = 25000000;
  localparam int VCB_BAUD_DEFAULT = 115200;
  localparam int VCB_BAUD_MIN = 9600;
  localparam int VCB_BAUD_MAX = 921600;
  localparam int VCB_DIV_W = 12;
  // clock cycles per bit, rounded down
  localparam logic [VCB_DIV_W-1:0] VCB_DIV_DEFAULT = VCB_DIV_W'(VCB_CLK_HZ / VCB_BAUD_DEFAULT);
  localparam logic [VCB_DIV_W-1:0] VCB_DIV_MIN = VCB_DIV_W'(VCB_CLK_HZ / VCB_BAUD_MAX);
  localparam logic [VCB_DIV_W-1:0] VCB_DIV_MAX = VCB_DIV_W'(VCB_CLK_HZ / VCB_BAUD_MIN);
  localparam logic [VCB_DIV_W-1:0] VCB_CNT_ONE = 12'h001;
  // character frame: start, 8 data, 1 stop
  localparam int VCB_DATA_BITS = 8;
  localparam int VCB_IDX_W = 4;
  localparam logic [VCB_IDX_W-1:0] VCB_IDX_START = 4'h0;
  localparam logic [VCB_IDX_W-1:0] VCB_IDX_STOP = 4'h9;
  localparam logic [VCB_IDX_W-1:0] VCB_IDX_ONE = 4'h1;
  // register map, byte addresses
  localparam int VCB_ADDR_W = 5;
  localparam logic [VCB_ADDR_W-1:0] VCB_REG_CTRL = 5'h00;
  localparam logic [VCB_ADDR_W-1:0] VCB_REG_DIV = 5'h04;
  localparam logic [VCB_ADDR_W-1:0] VCB_REG_STATUS = 5'h08;
  localparam logic [VCB_ADDR_W-1:0] VCB_REG_TXDATA = 5'h0c;
  localparam logic [VCB_ADDR_W-1:0] VCB_REG_RXDATA = 5'h10;
  // status bit positions
  localparam int VCB_ST_TX_BUSY = 0;
  localparam int VCB_ST_RX_FULL = 1;
  localparam int VCB_ST_OVERRUN = 2;
  localparam int VCB_ST_FRAME_ERR = 3;
  localparam int VCB_ST_TGT_READY = 4;
  localparam int VCB_ST_LINK_EN = 5;
  // bus responses
  localparam logic [1:0] VCB_RESP_OKAY = 2'h0;
  localparam logic [1:0] VCB_RESP_SLVERR = 2'h2;
  localparam int VCB_HS_W = 2;
  // handshake modes, codes 0..3 in this order
  typedef enum logic [VCB_HS_W-1:0] {
    VCB_HS_OFF,
    VCB_HS_INBOUND,
    VCB_HS_OUTBOUND,
    VCB_HS_BOTH
  } vcb_hs_t;
  typedef enum logic {VCB_TX_IDLE, VCB_TX_SEND} vcb_tx_t;
  typedef enum logic {VCB_RX_IDLE, VCB_RX_RECV} vcb_rx_t;
endpackage

// ===== common/vcb_link_if.sv
/*
  vcb_link_if: the four-wire serial link plus link enable between the
  board controller end and the target end.
  assumes the testbench instantiates it and joins both ends.
*/
`timescale 1ns/100ps
interface vcb_link_if;
  logic t2c_data;
  logic c2t_data;
  logic c_ready_out_n;
  logic c_ready_oe;
  logic c_ready_n;
  logic t_ready_n;
  logic link_en;
  // undriven clear line is pulled to ready so the target is never stuck
  assign c_ready_n = c_ready_oe ? c_ready_out_n : 1'b0;
  modport ctrl (
    input t2c_data, t_ready_n, link_en,
    output c2t_data, c_ready_out_n, c_ready_oe
  );
  modport tgt (
    input c2t_data, c_ready_n,
    output t2c_data, t_ready_n, link_en
  );
endinterface

// ===== hw/vcb_ctrl_end.sv
/*
  vcb_ctrl_end: board controller end of the serial bridge, with an
  AXI4-Lite register slave for mode, bit rate, data and status.
  assumes inputs synchronous to core_clk and the link interface joined
  by the testbench to the target end.
*/
`timescale 1ns/100ps
module vcb_ctrl_end
  import vcb_pkg::*;
#(
  parameter int ADDR_W = VCB_ADDR_W
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // link
  vcb_link_if.ctrl link
);
  function automatic logic reg_ok(input logic [ADDR_W-1:0] a);
    return a == VCB_REG_CTRL || a == VCB_REG_DIV || a == VCB_REG_STATUS ||
           a == VCB_REG_TXDATA || a == VCB_REG_RXDATA;
  endfunction

  logic aw_hold, w_hold, do_wr, ar_take;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_any;
  vcb_hs_t mode;
  logic [VCB_DIV_W-1:0] div;
  logic [VCB_DIV_W-1:0] next_div;
  logic tx_pend, tx_start;
  logic [VCB_DATA_BITS-1:0] tx_hold;
  logic rx_full, rx_clear, overrun, frame_err;
  logic [VCB_DATA_BITS-1:0] rx_data;
  logic [31:0] rd_val;
  vcb_tx_t tx_st;
  logic [VCB_DATA_BITS+1:0] tx_sh;
  logic [VCB_DIV_W-1:0] tx_cnt, tx_div;
  logic [VCB_IDX_W-1:0] tx_idx;
  logic c2t;
  vcb_rx_t rx_st;
  logic [VCB_DATA_BITS-1:0] rx_sh;
  logic [VCB_DIV_W-1:0] rx_cnt, rx_div;
  logic [VCB_IDX_W-1:0] rx_idx;
  logic rx_done, rx_bad_stop;
  logic cts_oe, cts_n;

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign do_wr = aw_hold && w_hold;
  assign wr_any = do_wr && (w_strb != 4'h0);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      aw_addr <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_hold <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      w_hold <= 1'b0;
      w_data <= '0;
      w_strb <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_wr) begin
        w_hold <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= VCB_RESP_OKAY;
    end else if (ce) begin
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_ok(aw_addr) ? VCB_RESP_OKAY : VCB_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // clamp keeps the divider inside the supported rate span
  always_comb begin
    next_div = w_data[VCB_DIV_W-1:0];
    if (w_data[31:VCB_DIV_W] != '0 || next_div > VCB_DIV_MAX) next_div = VCB_DIV_MAX;
    else if (next_div < VCB_DIV_MIN) next_div = VCB_DIV_MIN;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode <= VCB_HS_OFF;
      div <= VCB_DIV_DEFAULT;
    end else if (ce && wr_any) begin
      if (aw_addr == VCB_REG_CTRL) mode <= vcb_hs_t'(w_data[VCB_HS_W-1:0]);
      if (aw_addr == VCB_REG_DIV) div <= next_div;
    end
  end

  // a write while a character is pending is dropped
  assign tx_start = (tx_st == VCB_TX_IDLE) && tx_pend && link.link_en &&
    (!(mode == VCB_HS_OUTBOUND || mode == VCB_HS_BOTH) || !link.t_ready_n);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_pend <= 1'b0;
      tx_hold <= '0;
    end else if (ce) begin
      if (wr_any && aw_addr == VCB_REG_TXDATA && !tx_pend) begin
        tx_pend <= 1'b1;
        tx_hold <= w_data[VCB_DATA_BITS-1:0];
      end else if (tx_start) begin
        tx_pend <= 1'b0;
      end
    end
  end

  // read channel: one cycle to rvalid
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rx_clear = ar_take && s_axi_araddr == VCB_REG_RXDATA;

  always_comb begin
    rd_val = '0;
    case (s_axi_araddr)
      VCB_REG_CTRL: rd_val[VCB_HS_W-1:0] = mode;
      VCB_REG_DIV: rd_val[VCB_DIV_W-1:0] = div;
      VCB_REG_STATUS: begin
        rd_val[VCB_ST_TX_BUSY] = tx_pend || tx_st == VCB_TX_SEND;
        rd_val[VCB_ST_RX_FULL] = rx_full;
        rd_val[VCB_ST_OVERRUN] = overrun;
        rd_val[VCB_ST_FRAME_ERR] = frame_err;
        rd_val[VCB_ST_TGT_READY] = !link.t_ready_n;
        rd_val[VCB_ST_LINK_EN] = link.link_en;
      end
      VCB_REG_RXDATA: rd_val[VCB_DATA_BITS-1:0] = rx_data;
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= VCB_RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= reg_ok(s_axi_araddr) ? VCB_RESP_OKAY : VCB_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // transmitter toward the target; rate latched per character
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_st <= VCB_TX_IDLE;
      tx_sh <= '1;
      tx_cnt <= '0;
      tx_div <= VCB_DIV_DEFAULT;
      tx_idx <= '0;
      c2t <= 1'b1;
    end else if (ce) begin
      unique case (tx_st)
        VCB_TX_IDLE: if (tx_start) begin
          tx_st <= VCB_TX_SEND;
          tx_sh <= {1'b1, tx_hold, 1'b0};
          tx_cnt <= div;
          tx_div <= div;
          tx_idx <= '0;
          c2t <= 1'b0;
        end
        VCB_TX_SEND: if (tx_cnt == VCB_CNT_ONE) begin
          tx_cnt <= tx_div;
          // request line is not looked at here: the frame always completes
          if (tx_idx == VCB_IDX_STOP) begin
            tx_st <= VCB_TX_IDLE;
          end else begin
            tx_sh <= tx_sh >> 1;
            c2t <= tx_sh[1];
            tx_idx <= tx_idx + VCB_IDX_ONE;
          end
        end else begin
          tx_cnt <= tx_cnt - VCB_CNT_ONE;
        end
      endcase
    end
  end
  assign link.c2t_data = c2t;

  // receiver from the target, sampling mid-bit
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_st <= VCB_RX_IDLE;
      rx_sh <= '0;
      rx_cnt <= '0;
      rx_div <= VCB_DIV_DEFAULT;
      rx_idx <= '0;
      rx_done <= 1'b0;
      rx_bad_stop <= 1'b0;
    end else if (ce) begin
      rx_done <= 1'b0;
      unique case (rx_st)
        VCB_RX_IDLE: if (link.link_en && !link.t2c_data) begin
          rx_st <= VCB_RX_RECV;
          rx_cnt <= div >> 1;
          rx_div <= div;
          rx_idx <= VCB_IDX_START;
        end
        VCB_RX_RECV: if (rx_cnt == VCB_CNT_ONE) begin
          rx_cnt <= rx_div;
          rx_idx <= rx_idx + VCB_IDX_ONE;
          if (rx_idx == VCB_IDX_START && link.t2c_data) begin
            rx_st <= VCB_RX_IDLE;
          end else if (rx_idx == VCB_IDX_STOP) begin
            rx_st <= VCB_RX_IDLE;
            rx_done <= 1'b1;
            rx_bad_stop <= !link.t2c_data;
          end else if (rx_idx != VCB_IDX_START) begin
            rx_sh <= {link.t2c_data, rx_sh[VCB_DATA_BITS-1:1]};
          end
        end else begin
          rx_cnt <= rx_cnt - VCB_CNT_ONE;
        end
      endcase
    end
  end

  // holding register; a new character wins over a read in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_full <= 1'b0;
      rx_data <= '0;
    end else if (ce) begin
      if (rx_done) begin
        rx_full <= 1'b1;
        if (!rx_full || rx_clear) rx_data <= rx_sh;
      end else if (rx_clear) begin
        rx_full <= 1'b0;
      end
    end
  end

  // sticky errors, write one to clear, set wins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      overrun <= 1'b0;
      frame_err <= 1'b0;
    end else if (ce) begin
      if (rx_done && rx_full && !rx_clear) overrun <= 1'b1;
      else if (wr_any && aw_addr == VCB_REG_STATUS && w_data[VCB_ST_OVERRUN]) overrun <= 1'b0;
      if (rx_done && rx_bad_stop) frame_err <= 1'b1;
      else if (wr_any && aw_addr == VCB_REG_STATUS && w_data[VCB_ST_FRAME_ERR]) frame_err <= 1'b0;
    end
  end

  // clear line: high means stop, driven only in the throttling modes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cts_oe <= 1'b0;
      cts_n <= 1'b1;
    end else if (ce) begin
      cts_oe <= mode == VCB_HS_INBOUND || mode == VCB_HS_BOTH;
      cts_n <= rx_full;
    end
  end
  assign link.c_ready_oe = cts_oe;
  assign link.c_ready_out_n = cts_n;
endmodule // vcb_ctrl_end

// ===== hw/vcb_tgt_end.sv
/*
  vcb_tgt_end: target processor end of the serial bridge, a plain
  character port with flow control on both ready lines.
  assumes inputs synchronous to core_clk and the user side handshakes.
*/
`timescale 1ns/100ps
module vcb_tgt_end
  import vcb_pkg::*;
#(
  parameter logic [VCB_DIV_W-1:0] DIV = VCB_DIV_DEFAULT
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire logic link_on,
  input wire logic hs_en,
  // transmit stream
  input wire logic [VCB_DATA_BITS-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // receive stream
  output logic [VCB_DATA_BITS-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // link
  vcb_link_if.tgt link
);
  vcb_tx_t tx_st;
  logic [VCB_DATA_BITS+1:0] tx_sh;
  logic [VCB_DIV_W-1:0] tx_cnt, rx_cnt;
  logic [VCB_IDX_W-1:0] tx_idx, rx_idx;
  logic t2c, en, rts_n, take, spare_v, rx_done;
  vcb_rx_t rx_st;
  logic [VCB_DATA_BITS-1:0] rx_sh, spare_d;

  // clear line sampled before each character
  assign tx_ready = tx_st == VCB_TX_IDLE && en && (!hs_en || !link.c_ready_n);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_st <= VCB_TX_IDLE;
      tx_sh <= '1;
      tx_cnt <= '0;
      tx_idx <= '0;
      t2c <= 1'b1;
    end else if (ce) begin
      unique case (tx_st)
        VCB_TX_IDLE: if (tx_valid && tx_ready) begin
          tx_st <= VCB_TX_SEND;
          tx_sh <= {1'b1, tx_data, 1'b0};
          tx_cnt <= DIV;
          tx_idx <= '0;
          t2c <= 1'b0;
        end
        VCB_TX_SEND: if (tx_cnt == VCB_CNT_ONE) begin
          tx_cnt <= DIV;
          if (tx_idx == VCB_IDX_STOP) begin
            tx_st <= VCB_TX_IDLE;
          end else begin
            tx_sh <= tx_sh >> 1;
            t2c <= tx_sh[1];
            tx_idx <= tx_idx + VCB_IDX_ONE;
          end
        end else begin
          tx_cnt <= tx_cnt - VCB_CNT_ONE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_st <= VCB_RX_IDLE;
      rx_sh <= '0;
      rx_cnt <= '0;
      rx_idx <= '0;
      rx_done <= 1'b0;
    end else if (ce) begin
      rx_done <= 1'b0;
      unique case (rx_st)
        VCB_RX_IDLE: if (!link.c2t_data) begin
          rx_st <= VCB_RX_RECV;
          rx_cnt <= DIV >> 1;
          rx_idx <= VCB_IDX_START;
        end
        VCB_RX_RECV: if (rx_cnt == VCB_CNT_ONE) begin
          rx_cnt <= DIV;
          rx_idx <= rx_idx + VCB_IDX_ONE;
          if (rx_idx == VCB_IDX_START && link.c2t_data) begin
            rx_st <= VCB_RX_IDLE;
          end else if (rx_idx == VCB_IDX_STOP) begin
            rx_st <= VCB_RX_IDLE;
            rx_done <= 1'b1;
          end else if (rx_idx != VCB_IDX_START) begin
            rx_sh <= {link.c2t_data, rx_sh[VCB_DATA_BITS-1:1]};
          end
        end else begin
          rx_cnt <= rx_cnt - VCB_CNT_ONE;
        end
      endcase
    end
  end

  // spare slot catches the character already under way at deassert
  assign take = rx_valid && rx_ready;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      rx_data <= '0;
      spare_v <= 1'b0;
      spare_d <= '0;
    end else if (ce) begin
      if (rx_done) begin
        if (!rx_valid || (take && !spare_v)) begin
          rx_valid <= 1'b1;
          rx_data <= rx_sh;
        end else if (take) begin
          rx_data <= spare_d;
          spare_d <= rx_sh;
        end else begin
          spare_v <= 1'b1;
          spare_d <= rx_sh;
        end
      end else if (take) begin
        rx_valid <= spare_v;
        rx_data <= spare_d;
        spare_v <= 1'b0;
      end
    end
  end

  // request line driven from reset onward
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rts_n <= 1'b0;
      en <= 1'b0;
    end else if (ce) begin
      rts_n <= rx_valid;
      en <= link_on;
    end
  end
  assign link.t2c_data = t2c;
  assign link.t_ready_n = rts_n;
  assign link.link_en = en;
endmodule // vcb_tgt_end

// ===== bench/vcb_link_chk.sv
/*
  vcb_link_chk: concurrent checks on the serial link joining the two ends.
  assumes both ends run DIV cycles per bit once the link is enabled.
*/
`timescale 1ns/100ps
module vcb_link_chk #(
  parameter int DIV = 27
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // link
  input wire logic t2c_data,
  input wire logic c2t_data,
  input wire logic c_ready_out_n,
  input wire logic c_ready_oe,
  input wire logic t_ready_n,
  input wire logic link_en
);
  localparam int FR = 10 * DIV;
  logic [1:0] line_q;
  logic [1:0] start;
  logic [11:0] pos [2];
  // frame position per line, 0 = idle; lane 0 c2t, lane 1 t2c
  assign start[0] = pos[0] == 12'h000 && line_q[0] && !c2t_data;
  assign start[1] = pos[1] == 12'h000 && line_q[1] && !t2c_data;
  always_ff @(posedge core_clk) begin
    line_q <= {t2c_data, c2t_data};
  end
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (!rst_n) pos[i] <= 12'h000;
      else if (start[i]) pos[i] <= 12'h001;
      else if (pos[i] != 12'h000) pos[i] <= (pos[i] == 12'(FR - 1)) ? 12'h000 : pos[i] + 12'h001;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_reset_idle: assert property ($rose(rst_n) |-> c2t_data && t2c_data && !c_ready_oe && !link_en)
    else $error("link not idle after reset");
  a_c2t_start_low: assert property (pos[0] == 12'(DIV / 2) |-> !c2t_data)
    else $error("c2t start bit not low");
  a_c2t_stop_high: assert property (pos[0] == 12'(9 * DIV + DIV / 2) |-> c2t_data)
    else $error("c2t stop bit not high");
  a_t2c_stop_high: assert property (pos[1] == 12'(9 * DIV + DIV / 2) |-> t2c_data)
    else $error("t2c stop bit not high");
  a_c2t_link_on: assert property (start[0] |-> $past(link_en))
    else $error("c2t char started with link off");
  a_t2c_link_on: assert property (start[1] |-> $past(link_en))
    else $error("t2c char started with link off");
  // full flag is only set as a char lands, so the clear line may only rise then
  a_clear_on_full: assert property ($rose(c_ready_out_n) |-> pos[1] > 12'(9 * DIV))
    else $error("clear line rose outside a char end");
  a_rts_on_full: assert property ($rose(t_ready_n) |-> pos[0] > 12'(9 * DIV))
    else $error("request line rose outside a char end");
endmodule // vcb_link_chk

// ===== bench/tb.sv
/*
  tb: joins controller and target ends over the link and runs the scenarios.
  assumes a 25 MHz core clock and a bit time of DV cycles on both ends.
*/
`timescale 1ns/100ps
module tb;
  import vcb_pkg::*;
  localparam int DV = 27;
  logic core_clk, rst_n, link_on, hs_en, tx_valid, rx_ready;
  logic awv, wv, bready, arv, rready, awready, wready, bvalid, arready, rvalid;
  logic tx_ready, rx_valid;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rd, rdata;
  logic [7:0] tx_data, rx_data;
  logic [1:0] bresp, rresp, rs, bs;
  int n_tests = 0;
  int miscompares = 0;
  vcb_link_if link ();
  vcb_ctrl_end vcb_ctrl_end_i (.core_clk(core_clk), .rst_n(rst_n), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link(link));
  vcb_tgt_end #(.DIV(12'(DV))) vcb_tgt_end_i (.core_clk(core_clk), .rst_n(rst_n), .ce(1'b1),
    .link_on(link_on), .hs_en(hs_en), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .link(link));
  vcb_link_chk #(.DIV(DV)) vcb_link_chk_i (.core_clk(core_clk), .rst_n(rst_n),
    .t2c_data(link.t2c_data), .c2t_data(link.c2t_data), .c_ready_out_n(link.c_ready_out_n),
    .c_ready_oe(link.c_ready_oe), .t_ready_n(link.t_ready_n), .link_en(link.link_en));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // bus waits are open ended, the watchdog ends a hang
  task automatic axw(input logic [4:0] a, input logic [31:0] d);
    logic b;
    b = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
      if (bvalid) begin
        b = 1'b1;
        bs = bresp;
      end
    end while (!b);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [4:0] a);
    logic r;
    r = 1'b0;
    @(posedge core_clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arv <= 1'b0;
      if (rvalid) r = 1'b1;
    end while (!r);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic wst(input int b, input logic v);
    int i;
    i = 0;
    do begin
      axr(VCB_REG_STATUS);
      i++;
    end while (rd[b] !== v && i < 300);
  endtask
  task automatic tsend(input logic [7:0] d);
    @(posedge core_clk);
    tx_data <= d;
    tx_valid <= 1'b1;
    do @(posedge core_clk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask
  task automatic trecv(input logic [7:0] d);
    int i;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (rx_valid !== 1'b1 && i < 1000);
    chk(32'(rx_data), 32'(d));
  endtask
  task automatic t_reset();
    axr(VCB_REG_DIV);
    chk(rd, 32'(VCB_DIV_DEFAULT));
    chk(32'(rs), 32'(VCB_RESP_OKAY));
    axr(VCB_REG_CTRL);
    chk(32'(rd[1:0]), 32'(VCB_HS_OFF));
    chk(32'(link.c_ready_oe), 32'h0);
    chk(32'(link.t_ready_n), 32'h0);
    axr(VCB_REG_STATUS);
    chk(rd, 32'h1 << VCB_ST_TGT_READY);
    axr(5'h14);
    chk(32'(rs), 32'(VCB_RESP_SLVERR));
    // unmapped write must leave the handshake mode alone
    axw(5'h14, 32'(VCB_HS_BOTH));
    chk(32'(bs), 32'(VCB_RESP_SLVERR));
    axr(VCB_REG_CTRL);
    chk(rd, 32'(VCB_HS_OFF));
    axw(VCB_REG_DIV, 32'h0000000a);
    chk(32'(bs), 32'(VCB_RESP_OKAY));
    axr(VCB_REG_DIV);
    chk(rd, 32'(VCB_DIV_MIN));
    axw(VCB_REG_DIV, 32'h00001388);
    axr(VCB_REG_DIV);
    chk(rd, 32'(VCB_DIV_MAX));
    axw(VCB_REG_DIV, 32'(DV));
    $display("reset test done");
  endtask
  task automatic t_link();
    logic [7:0] bits;
    int i;
    axw(VCB_REG_TXDATA, 32'h0000005a);
    repeat (300) @(posedge core_clk);
    chk(32'(link.c2t_data), 32'h1);
    axr(VCB_REG_STATUS);
    chk(32'(rd[VCB_ST_TX_BUSY]), 32'h1);
    link_on <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (link.c2t_data !== 1'b0 && i < 1000);
    repeat (DV / 2) @(posedge core_clk);
    for (i = 0; i < 8; i++) begin
      repeat (DV) @(posedge core_clk);
      bits[i] = link.c2t_data;
    end
    chk(32'(bits), 32'h0000005a);
    trecv(8'h5a);
    $display("link test done");
  endtask
  task automatic t_rx();
    tsend(8'ha5);
    wst(VCB_ST_RX_FULL, 1'b1);
    // off mode never throttles the target, so a second char overruns
    tsend(8'h5b);
    wst(VCB_ST_OVERRUN, 1'b1);
    chk(32'(rd[VCB_ST_OVERRUN]), 32'h1);
    chk(32'(rd[VCB_ST_FRAME_ERR]), 32'h0);
    chk(32'(rd[VCB_ST_LINK_EN]), 32'h1);
    axr(VCB_REG_RXDATA);
    chk(rd, 32'h000000a5);
    axw(VCB_REG_STATUS, 32'h1 << VCB_ST_OVERRUN);
    axr(VCB_REG_STATUS);
    chk(32'(rd[VCB_ST_OVERRUN]), 32'h0);
    chk(32'(rd[VCB_ST_RX_FULL]), 32'h0);
    $display("rx test done");
  endtask
  task automatic t_inbound();
    logic seen;
    seen = 1'b0;
    hs_en <= 1'b1;
    axw(VCB_REG_CTRL, 32'(VCB_HS_INBOUND));
    tsend(8'h11);
    wst(VCB_ST_RX_FULL, 1'b1);
    repeat (4) @(posedge core_clk);
    chk(32'(link.c_ready_oe), 32'h1);
    chk(32'(link.c_ready_n), 32'h1);
    tx_data <= 8'h22;
    tx_valid <= 1'b1;
    repeat (300) begin
      @(posedge core_clk);
      if (tx_ready === 1'b1) seen = 1'b1;
    end
    chk(32'(seen), 32'h0);
    axr(VCB_REG_RXDATA);
    chk(rd, 32'h00000011);
    do @(posedge core_clk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
    wst(VCB_ST_RX_FULL, 1'b1);
    axr(VCB_REG_RXDATA);
    chk(rd, 32'h00000022);
    axr(VCB_REG_STATUS);
    chk(32'(rd[VCB_ST_OVERRUN]), 32'h0);
    $display("inbound test done");
  endtask
  // off and outbound share the stalled-target setup; the mode decides the outcome
  task automatic t_stall(input vcb_hs_t m, input logic [7:0] b1, input logic [7:0] b2);
    axw(VCB_REG_CTRL, 32'(m));
    rx_ready <= 1'b0;
    axw(VCB_REG_TXDATA, 32'(b1));
    trecv(b1);
    repeat (3) @(posedge core_clk);
    chk(32'(link.c_ready_oe), 32'h0);
    chk(32'(link.t_ready_n), 32'h1);
    axw(VCB_REG_TXDATA, 32'(b2));
    repeat (600) @(posedge core_clk);
    axr(VCB_REG_STATUS);
    chk(32'(rd[VCB_ST_TX_BUSY]), 32'(m == VCB_HS_OUTBOUND));
    rx_ready <= 1'b1;
    trecv(b1);
    trecv(b2);
    $display("stall test done");
  endtask
  task automatic t_both();
    axw(VCB_REG_CTRL, 32'(VCB_HS_BOTH));
    tsend(8'hc6);
    wst(VCB_ST_RX_FULL, 1'b1);
    repeat (3) @(posedge core_clk);
    chk(32'(link.c_ready_n), 32'h1);
    axr(VCB_REG_RXDATA);
    chk(rd, 32'h000000c6);
    axw(VCB_REG_TXDATA, 32'h0000007e);
    trecv(8'h7e);
    $display("both test done");
  endtask
  initial begin
    rst_n = 1'b0;
    link_on = 1'b0;
    hs_en = 1'b0;
    tx_valid = 1'b0;
    rx_ready = 1'b1;
    {awv, wv, bready, arv, rready} = 5'h00;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h00000000;
    tx_data = 8'h00;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_link();
    t_rx();
    t_inbound();
    t_stall(VCB_HS_OFF, 8'h3c, 8'hc3);
    t_stall(VCB_HS_OUTBOUND, 8'h81, 8'h18);
    t_both();
    conclude();
  end
  // all scenarios take about 5000 cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    miscompares++;
    conclude();
  end
endmodule // tb
